// ---- design/acl_defs.svh ----
`ifndef ACL_DEFS_SVH
`define ACL_DEFS_SVH

// task file offsets
`define ACL_OFF_OPTION  3'h1
`define ACL_OFF_COUNT   3'h2
`define ACL_OFF_SECTOR  3'h3
`define ACL_OFF_TRK_LO  3'h4
`define ACL_OFF_TRK_HI  3'h5
`define ACL_OFF_UNIT    3'h6
`define ACL_OFF_CMD     3'h7

// field positions
`define ACL_DC_HOB_BIT  7
`define ACL_UNIT_DRV    4
`define ACL_UNIT_LBA    6
`define ACL_HEAD_MSB    3

// status and error values
`define ACL_ST_GOOD     8'h50
`define ACL_ST_ERR      8'h51
`define ACL_ER_NONE     8'h00
`define ACL_ER_ABORT    8'h04

// transfer sizing
`define ACL_FIS_MAX_DW  12'h800
`define ACL_SEC_SHIFT   7
`define ACL_SEC28_ZERO  17'h00100
`define ACL_SEC48_ZERO  17'h10000

// command codes
`define ACL_OP_RD_DMA   8'hc8
`define ACL_OP_RD_DMAX  8'h25
`define ACL_OP_MAX_RD   8'hf8
`define ACL_OP_MAX_RDX  8'h27
`define ACL_OP_MAX_SET  8'hf9
`define ACL_OP_MAX_SETX 8'h37
`define ACL_OP_SEC_PW   8'hf1
`define ACL_OP_SEC_UNL  8'hf2
`define ACL_OP_SEC_EPR  8'hf3
`define ACL_OP_SEC_ERA  8'hf4
`define ACL_OP_SEC_FRZ  8'hf5
`define ACL_OP_SEC_DIS  8'hf6
`define ACL_OP_VFY_A    8'h40
`define ACL_OP_VFY_B    8'h41
`define ACL_OP_VFY_X    8'h42
`define ACL_OP_DIAG     8'h90
`define ACL_OP_FLUSH    8'he7
`define ACL_OP_FLUSHX   8'hea
`define ACL_OP_FORMAT   8'h50
`define ACL_OP_SETFEAT  8'hef
`define ACL_OP_HEALTH   8'hb0
`define ACL_OP_IDENT    8'hec
`define ACL_OP_NOP      8'h00
`define ACL_NIB_RECAL   4'h1
`define ACL_NIB_SEEK    4'h7

`endif

// ---- design/acl_pkg.sv ----
package acl_pkg;

  // command sequencer states, gray along idle-prepare-payload-status
  typedef enum logic [1:0] {
    device_idle_state         = 2'h0,
    dma_in_prepare_state      = 2'h1,
    dma_in_send_payload_state = 2'h3,
    dma_in_send_status_state  = 2'h2
  } acl_state_type;

  // per-command decode of task file usage
  typedef struct packed {
    logic known;   // recognised code
    logic nop;     // legacy code completed as no-op
    logic dma_in;  // dma data-in flow
    logic ext;     // double_write_marker: 48-bit doubled writes
    logic spec;    // fields carry command-specific data
    logic opt_y;   // option byte used
    logic cnt_y;   // count used
    logic sec_y;   // sector index used
    logic trk_y;   // track bytes used
    logic head_y;  // head field used as well as drive bit
  } acl_dec_type;

  // parameters handed to command execution
  typedef struct packed {
    logic [7:0]  opcode;
    logic [15:0] option;
    logic [15:0] count;
    logic [47:0] lba;
    logic        lba_mode;
    logic        drive;
    logic [3:0]  head;
    logic        ext;
    logic        nop;
    logic        spec;
  } acl_cmd_type;

  // ending register contents for the status fis
  typedef struct packed {
    logic        ibit;
    logic [7:0]  status;
    logic [7:0]  error;
    logic [15:0] count;
    logic [47:0] lba;
    logic [7:0]  unit;
  } acl_sfis_type;

endpackage

// ---- design/acl_fifo.sv ----
`timescale 1ns/1ps
module acl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,    // clock
  input  wire logic             rst_n,      // synchronised reset
  input  wire logic             in_valid,   // write request
  output logic                  in_ready,   // space available
  input  wire logic [WIDTH-1:0] in_data,    // write word
  output logic                  out_valid,  // word available
  input  wire logic             out_ready,  // pop
  output logic      [WIDTH-1:0] out_data    // head word
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("bad fifo depth");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_ready && out_valid;
  assign out_data = mem[rd_ptr_ff];

  // occupancy
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // pointers and registered flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      cnt_ff    <= nxt_cnt;
      in_ready  <= nxt_cnt != (AW+1)'(DEPTH);
      out_valid <= nxt_cnt != '0;
    end
  end

  // storage
  always_ff @(posedge sys_clk) begin
    if (push) mem[wr_ptr_ff] <= in_data;
  end
endmodule

// ---- design/acl_core.sv ----
// How it works
// - enter prepare on dma-in command or more data
// - prepare goes to payload once data ready
// - prepare goes to status when done or aborted
// - payload requests one fis, at most 2048 dwords
// - payload returns to prepare on fis done
// - status sends register fis, interrupt bit set
// - status goes idle after fis transmitted
// - legacy codes complete as no-operation
// - doubled writes keep upper and lower byte
// - drive-only commands ignore the head field
// - unit-select used means drive and head
// - only registers used by command are valid
// - command-specific registers passed raw, uninterpreted
// - control bit7 selects upper or lower readback
// - decode max address read and set codes
// - decode security commands as drive-only
// - decode verify 40h/41h and 48-bit 42h
// - decode diagnostic, flush and 48-bit flush
// - decode format track with count, track, unit
`timescale 1ns/1ps
`include "acl_defs.svh"
module acl_core import acl_pkg::*; #(
  parameter int DW         = 32,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic          sys_clk,     // 125 mhz clock
  input  wire logic          rst_n,       // async reset, active low
  input  wire logic          tf_wr,       // task file write strobe
  input  wire logic          tf_rd,       // task file read strobe
  input  wire logic [2:0]    tf_addr,     // task file offset
  input  wire logic [7:0]    tf_wdata,    // task file write byte
  output logic      [7:0]    tf_rdata,    // read byte, next cycle
  input  wire logic          ctl_wr,      // device control write
  input  wire logic [7:0]    ctl_wdata,   // device control byte
  input  wire logic          media_valid, // media data word valid
  input  wire logic [DW-1:0] media_data,  // media data word
  output logic               media_ready, // fifo has room
  input  wire logic          media_err,   // media error pulse
  output logic               dfis_req,    // data fis request
  output logic      [11:0]   dfis_len,    // data fis dwords
  input  wire logic          dfis_done,   // data fis transferred
  output logic               tx_valid,    // payload dword valid
  output logic      [DW-1:0] tx_data,     // payload dword
  output logic               tx_last,     // last dword of fis
  input  wire logic          tx_ready,    // transport takes dword
  output logic               sfis_req,    // status fis request
  output acl_sfis_type       sfis_word,   // status fis content
  input  wire logic          sfis_done,   // status fis transmitted
  output logic               cmd_start,   // command launch pulse
  output acl_cmd_type        cmd_info,    // launched command
  output logic               busy         // command in progress
);
  if (DW < 1 || FIFO_DEPTH < 2) begin : g_chk
    $error("unsupported width or depth");
  end

  ////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_ff;
  logic       rst_n_s;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n_s = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////
  // task file, current and previous byte per register
  logic [7:0]    cur_ff  [1:6];
  logic [7:0]    prev_ff [1:6];
  logic          hob_ff;
  acl_state_type state_ff;
  acl_state_type nxt_state;
  logic          cmd_go;

  for (genvar i = 1; i <= 6; i++) begin : g_tf
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
        cur_ff[i]  <= 8'h00;
        prev_ff[i] <= 8'h00;
      end else if (tf_wr && tf_addr == 3'(i)) begin
        prev_ff[i] <= cur_ff[i];
        cur_ff[i]  <= tf_wdata;
      end
    end
  end

  // byte select for readback
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) hob_ff <= 1'b0;
    else if (ctl_wr) hob_ff <= ctl_wdata[`ACL_DC_HOB_BIT];
  end

  // command write launches only when idle
  assign cmd_go = tf_wr && tf_addr == `ACL_OFF_CMD && state_ff == device_idle_state;

  ////////////////////////////////////////////////////////////////////
  // command decode
  function automatic acl_dec_type decode(input logic [7:0] op);
    acl_dec_type d;
    d = '0;
    d.known = 1'b1;
    case (op)
      `ACL_OP_RD_DMA: begin
        {d.dma_in, d.cnt_y, d.sec_y, d.trk_y, d.head_y} = 5'h1f;
      end
      `ACL_OP_RD_DMAX: begin
        {d.dma_in, d.ext, d.cnt_y, d.sec_y, d.trk_y} = 5'h1f;
      end
      `ACL_OP_MAX_RD, `ACL_OP_MAX_RDX: begin
        d.ext = op == `ACL_OP_MAX_RDX;
      end
      `ACL_OP_MAX_SET, `ACL_OP_VFY_A, `ACL_OP_VFY_B: begin
        {d.cnt_y, d.sec_y, d.trk_y, d.head_y} = 4'hf;
      end
      `ACL_OP_MAX_SETX, `ACL_OP_VFY_X: begin
        {d.ext, d.cnt_y, d.sec_y, d.trk_y} = 4'hf;
      end
      `ACL_OP_SEC_PW, `ACL_OP_SEC_UNL, `ACL_OP_SEC_EPR,
      `ACL_OP_SEC_ERA, `ACL_OP_SEC_FRZ, `ACL_OP_SEC_DIS: begin
        d.known = 1'b1;
      end
      `ACL_OP_DIAG, `ACL_OP_FLUSH, `ACL_OP_IDENT, `ACL_OP_NOP: begin
        d.known = 1'b1;
      end
      `ACL_OP_FLUSHX: begin
        d.ext = 1'b1;
      end
      `ACL_OP_FORMAT: begin
        {d.cnt_y, d.trk_y, d.head_y} = 3'h7;
      end
      `ACL_OP_SETFEAT, `ACL_OP_HEALTH: begin
        {d.spec, d.opt_y, d.cnt_y} = {2'h3, op == `ACL_OP_HEALTH};
        d.trk_y = op == `ACL_OP_HEALTH;
      end
      default: begin
        if (op[7:4] == `ACL_NIB_RECAL || op[7:4] == `ACL_NIB_SEEK) begin
          d.nop = 1'b1;
        end else begin
          d.known = 1'b0;
        end
      end
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // parameter capture at launch
  acl_dec_type dec;
  acl_cmd_type nxt_info;
  logic [16:0] sectors;

  assign dec = decode(tf_wdata);

  always_comb begin
    nxt_info        = '0;
    nxt_info.opcode = tf_wdata;
    nxt_info.ext    = dec.ext;
    nxt_info.nop    = dec.nop;
    nxt_info.spec   = dec.spec;
    nxt_info.drive  = cur_ff[`ACL_OFF_UNIT][`ACL_UNIT_DRV];
    if (dec.head_y) begin
      nxt_info.head     = cur_ff[`ACL_OFF_UNIT][`ACL_HEAD_MSB:0];
      nxt_info.lba_mode = cur_ff[`ACL_OFF_UNIT][`ACL_UNIT_LBA];
    end
    // unused registers stay zero
    if (dec.opt_y) nxt_info.option[7:0] = cur_ff[`ACL_OFF_OPTION];
    if (dec.cnt_y) nxt_info.count[7:0] = cur_ff[`ACL_OFF_COUNT];
    if (dec.sec_y) nxt_info.lba[7:0] = cur_ff[`ACL_OFF_SECTOR];
    if (dec.trk_y) begin
      nxt_info.lba[23:8] = {cur_ff[`ACL_OFF_TRK_HI], cur_ff[`ACL_OFF_TRK_LO]};
    end
    if (dec.ext) begin
      nxt_info.lba_mode = 1'b1;
      if (dec.cnt_y) nxt_info.count[15:8] = prev_ff[`ACL_OFF_COUNT];
      if (dec.sec_y) nxt_info.lba[31:24] = prev_ff[`ACL_OFF_SECTOR];
      if (dec.trk_y) begin
        nxt_info.lba[47:32] = {prev_ff[`ACL_OFF_TRK_HI], prev_ff[`ACL_OFF_TRK_LO]};
      end
    end else if (dec.head_y && dec.sec_y) begin
      nxt_info.lba[27:24] = cur_ff[`ACL_OFF_UNIT][`ACL_HEAD_MSB:0];
    end
  end

  // sector count, zero meaning the largest transfer
  always_comb begin
    sectors = {1'b0, nxt_info.count};
    if (dec.ext && nxt_info.count == 16'h0) sectors = `ACL_SEC48_ZERO;
    else if (!dec.ext && nxt_info.count[7:0] == 8'h0) sectors = `ACL_SEC28_ZERO;
  end

  ////////////////////////////////////////////////////////////////////
  // data buffer
  logic          fifo_valid;
  logic [DW-1:0] fifo_data;
  logic          fifo_pop;

  acl_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n_s),
    .in_valid  (media_valid),
    .in_ready  (media_ready),
    .in_data   (media_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////
  // sequencer
  logic [23:0] remain_ff;
  logic [11:0] send_left_ff;
  logic        abort_ff;
  logic        err_end;
  logic [11:0] fis_len;

  assign fis_len = (remain_ff > 24'(`ACL_FIS_MAX_DW)) ?
                   `ACL_FIS_MAX_DW : remain_ff[11:0];

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      device_idle_state: begin
        if (cmd_go) begin
          if (dec.dma_in) nxt_state = dma_in_prepare_state;
          else nxt_state = dma_in_send_status_state;
        end
      end
      dma_in_prepare_state: begin
        if (abort_ff || remain_ff == 24'h0) begin
          nxt_state = dma_in_send_status_state;
        end else if (fifo_valid) begin
          nxt_state = dma_in_send_payload_state;
        end
      end
      dma_in_send_payload_state: begin
        if (dfis_done) nxt_state = dma_in_prepare_state;
      end
      dma_in_send_status_state: begin
        if (sfis_done) nxt_state = device_idle_state;
      end
      default: nxt_state = device_idle_state;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) state_ff <= device_idle_state;
    else state_ff <= nxt_state;
  end

  // error capture outside idle only, launch clears it or flags an unknown code
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) abort_ff <= 1'b0;
    else if (media_err && state_ff != device_idle_state) abort_ff <= 1'b1;
    else if (cmd_go) abort_ff <= !dec.known;
  end

  // dwords left for command and for current fis
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      remain_ff    <= 24'h0;
      send_left_ff <= 12'h0;
    end else begin
      if (cmd_go && dec.dma_in) begin
        remain_ff <= 24'(sectors) << `ACL_SEC_SHIFT;
      end else if (fifo_pop) begin
        remain_ff <= remain_ff - 24'h1;
      end
      if (state_ff == dma_in_prepare_state && nxt_state == dma_in_send_payload_state) begin
        send_left_ff <= fis_len;
      end else if (fifo_pop) begin
        send_left_ff <= send_left_ff - 12'h1;
      end
    end
  end

  // data fis request, held until transport reports it done
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      dfis_req <= 1'b0;
      dfis_len <= 12'h0;
    end else if (state_ff == dma_in_prepare_state && nxt_state == dma_in_send_payload_state) begin
      dfis_req <= 1'b1;
      dfis_len <= fis_len;
    end else if (dfis_done) begin
      dfis_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // payload stream through one output register
  assign fifo_pop = state_ff == dma_in_send_payload_state && send_left_ff != 12'h0 &&
                    fifo_valid && (!tx_valid || tx_ready);

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tx_valid <= 1'b0;
      tx_data  <= '0;
      tx_last  <= 1'b0;
    end else if (fifo_pop) begin
      tx_valid <= 1'b1;
      tx_data  <= fifo_data;
      tx_last  <= send_left_ff == 12'h1;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status fis with ending register contents, launch ignores a stale abort
  assign err_end = cmd_go ? !dec.known : abort_ff;
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sfis_req  <= 1'b0;
      sfis_word <= '0;
    end else if (state_ff != dma_in_send_status_state &&
                 nxt_state == dma_in_send_status_state) begin
      sfis_req       <= 1'b1;
      sfis_word.ibit <= 1'b1;
      sfis_word.status <= err_end ? `ACL_ST_ERR : `ACL_ST_GOOD;
      sfis_word.error <= err_end ? `ACL_ER_ABORT : `ACL_ER_NONE;
      sfis_word.count <= {prev_ff[`ACL_OFF_COUNT], cur_ff[`ACL_OFF_COUNT]};
      sfis_word.lba   <= {prev_ff[`ACL_OFF_TRK_HI], prev_ff[`ACL_OFF_TRK_LO],
                          prev_ff[`ACL_OFF_SECTOR], cur_ff[`ACL_OFF_TRK_HI],
                          cur_ff[`ACL_OFF_TRK_LO], cur_ff[`ACL_OFF_SECTOR]};
      sfis_word.unit  <= cur_ff[`ACL_OFF_UNIT];
    end else if (sfis_done) begin
      sfis_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // launch outputs and busy flag
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      cmd_start <= 1'b0;
      cmd_info  <= '0;
      busy      <= 1'b0;
    end else begin
      cmd_start <= cmd_go && dec.known && !dec.nop;
      if (cmd_go) cmd_info <= nxt_info;
      busy <= nxt_state != device_idle_state;
    end
  end

  // register readback, selected byte of doubled registers
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tf_rdata <= 8'h00;
    end else if (tf_rd) begin
      if (tf_addr == `ACL_OFF_OPTION) begin
        tf_rdata <= sfis_word.error;
      end else if (tf_addr == `ACL_OFF_CMD) begin
        tf_rdata <= busy ? 8'h80 : sfis_word.status;
      end else if (tf_addr >= `ACL_OFF_COUNT && tf_addr <= `ACL_OFF_UNIT) begin
        tf_rdata <= hob_ff ? prev_ff[tf_addr] : cur_ff[tf_addr];
      end else begin
        tf_rdata <= 8'h00;
      end
    end
  end
endmodule

// ---- bench/acl_checker.sv ----
`timescale 1ns/1ps
`include "acl_defs.svh"
module acl_checker import acl_pkg::*; #(
  parameter int DW = 32
) (
  input wire logic          sys_clk,   // clock
  input wire logic          rst_n,     // reset
  input wire logic          tf_wr,     // task file write
  input wire logic [2:0]    tf_addr,   // offset
  input wire logic          busy,      // in progress
  input wire logic          dfis_req,  // data fis request
  input wire logic [11:0]   dfis_len,  // dwords
  input wire logic          dfis_done, // fis sent
  input wire logic          tx_valid,  // payload valid
  input wire logic [DW-1:0] tx_data,   // payload
  input wire logic          tx_last,   // final dword
  input wire logic          tx_ready,  // taken
  input wire logic          sfis_req,  // status request
  input wire acl_sfis_type  sfis_word, // status content
  input wire logic          sfis_done  // status sent
);
  logic [11:0] beat_ff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////
  // payload beats within the current fis
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) beat_ff <= 12'h000;
    else if (dfis_done) beat_ff <= 12'h000;
    else if (tx_valid && tx_ready) beat_ff <= beat_ff + 12'h001;
  end
  ////////////////////////
  property p_len; dfis_req |-> dfis_len != 12'h000 && dfis_len <= `ACL_FIS_MAX_DW; endproperty
  a_len: assert property (p_len) else $error("fis length out of range");
  property p_hold; dfis_req && !dfis_done |=> dfis_req && $stable(dfis_len); endproperty
  a_hold: assert property (p_hold) else $error("fis request dropped");
  property p_ret; dfis_req && dfis_done |=> !dfis_req; endproperty
  a_ret: assert property (p_ret) else $error("no return to prepare");
  property p_txin; tx_valid |-> dfis_req; endproperty
  a_txin: assert property (p_txin) else $error("payload outside send");
  property p_txhold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_txhold: assert property (p_txhold) else $error("payload not held");
  property p_last; tx_valid && tx_ready |-> tx_last == (beat_ff + 12'h001 == dfis_len); endproperty
  a_last: assert property (p_last) else $error("last flag misplaced");
  property p_excl; !(dfis_req && sfis_req); endproperty
  a_excl: assert property (p_excl) else $error("data and status together");
  property p_ibit; sfis_req |-> sfis_word.ibit; endproperty
  a_ibit: assert property (p_ibit) else $error("interrupt bit clear");
  property p_idle; sfis_req && sfis_done |=> !sfis_req && !busy; endproperty
  a_idle: assert property (p_idle) else $error("not idle after status");
  property p_launch; tf_wr && tf_addr == `ACL_OFF_CMD && !busy |=> busy; endproperty
  a_launch: assert property (p_launch) else $error("command not launched");
  property p_abort; sfis_req && sfis_word.status == `ACL_ST_ERR |-> sfis_word.error == `ACL_ER_ABORT;
  endproperty
  a_abort: assert property (p_abort) else $error("abort code missing");
endmodule
bind acl_core acl_checker #(.DW(DW)) i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .tf_wr(tf_wr),
  .tf_addr(tf_addr), .busy(busy), .dfis_req(dfis_req), .dfis_len(dfis_len),
  .dfis_done(dfis_done), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .tx_ready(tx_ready), .sfis_req(sfis_req), .sfis_word(sfis_word), .sfis_done(sfis_done));

// ---- bench/acl_transport_model.sv ----
`timescale 1ns/1ps
module acl_transport_model (
  input  wire logic sys_clk,   // clock
  input  wire logic rst_n,     // reset
  input  wire logic slow,      // stall every other beat
  input  wire logic tx_valid,  // payload valid
  input  wire logic tx_last,   // final dword
  output logic      tx_ready,  // dword taken
  output logic      dfis_done, // data fis sent
  input  wire logic sfis_req,  // status request
  output logic      sfis_done  // status sent
);
  logic [1:0] wait_ff;
  // accept payload, throttled when slow
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) tx_ready <= 1'b0;
    else tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // fis done one cycle after the final dword
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) dfis_done <= 1'b0;
    else dfis_done <= tx_valid && tx_ready && tx_last;
  end
  // status fis leaves after a few cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 2'h0;
      sfis_done <= 1'b0;
    end else begin
      sfis_done <= sfis_req && !sfis_done && wait_ff == 2'h3;
      wait_ff <= (sfis_req && !sfis_done) ? wait_ff + 2'h1 : 2'h0;
    end
  end
endmodule

// ---- bench/ata_command_layer_tb.sv ----
`timescale 1ns/1ps
`include "acl_defs.svh"
module ata_command_layer_tb import acl_pkg::*; ;
  logic sys_clk, rst_n, tf_wr, tf_rd, ctl_wr, media_valid, media_ready, media_err, slow;
  logic dfis_req, dfis_done, tx_valid, tx_last, tx_ready, sfis_req, sfis_done, cmd_start, busy;
  logic [2:0] tf_addr;
  logic [7:0] tf_wdata, tf_rdata, ctl_wdata;
  logic [11:0] dfis_len;
  logic [31:0] media_data, tx_data, mcnt, mtop, tcnt;
  acl_sfis_type sfis_word;
  acl_cmd_type cmd_info;
  int fails, checks_done;
  ////////////////////////
  acl_core #(.DW(32), .FIFO_DEPTH(32)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_addr(tf_addr), .tf_wdata(tf_wdata),
    .tf_rdata(tf_rdata), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .media_valid(media_valid),
    .media_data(media_data), .media_ready(media_ready), .media_err(media_err),
    .dfis_req(dfis_req), .dfis_len(dfis_len), .dfis_done(dfis_done), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .sfis_req(sfis_req),
    .sfis_word(sfis_word), .sfis_done(sfis_done), .cmd_start(cmd_start),
    .cmd_info(cmd_info), .busy(busy));
  acl_transport_model i_xpt (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .dfis_done(dfis_done),
    .sfis_req(sfis_req), .sfis_done(sfis_done));
  ////////////////////////
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // media source, counting words
  always @(negedge sys_clk) begin
    media_valid <= mcnt < mtop;
    media_data <= mcnt;
  end
  always @(posedge sys_clk) if (media_valid && media_ready) mcnt <= mcnt + 32'h1;
  // payload keeps media order
  always @(posedge sys_clk) begin
    if (rst_n && tx_valid && tx_ready) begin
      chk(tx_data, tcnt, "payload order");
      tcnt <= tcnt + 32'h1;
    end
  end
  ////////////////////////
  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    tf_wr = 1'b1;
    tf_addr = a;
    tf_wdata = d;
    @(negedge sys_clk);
    tf_wr = 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    tf_rd = 1'b1;
    tf_addr = a;
    @(negedge sys_clk);
    tf_rd = 1'b0;
    d = tf_rdata;
  endtask
  task ctl(input logic [7:0] d);
    @(negedge sys_clk);
    ctl_wr = 1'b1;
    ctl_wdata = d;
    @(negedge sys_clk);
    ctl_wr = 1'b0;
  endtask
  task fin(input logic [7:0] st, input logic [7:0] er);
    int n;
    n = 0;
    while (sfis_req !== 1'b1 && n < 9000) @(negedge sys_clk) n++;
    chk({sfis_req, sfis_word.status}, {1'b1, st}, "status");
    chk(sfis_word.error, er, "error");
    chk(sfis_word.ibit, 1'b1, "ibit");
    while (busy !== 1'b0 && n < 9000) @(negedge sys_clk) n++;
    chk({busy, sfis_req}, 2'h0, "idle");
  endtask
  task wfis(input logic [11:0] len, input logic ab);
    int n;
    n = 0;
    while (dfis_req !== 1'b1 && n < 9000) @(negedge sys_clk) n++;
    chk({dfis_req, dfis_len}, {1'b1, len}, "fis length");
    if (ab) begin
      media_err = 1'b1;
      @(negedge sys_clk);
      media_err = 1'b0;
    end
    while (dfis_req !== 1'b0 && n < 9000) @(negedge sys_clk) n++;
  endtask
  ////////////////////////
  task t_regs;
    logic [7:0] d;
    wr(`ACL_OFF_COUNT, 8'hab);
    wr(`ACL_OFF_COUNT, 8'hcd);
    ctl(8'h80);
    rd(`ACL_OFF_COUNT, d);
    chk(d, 8'hab, "upper byte");
    ctl(8'h00);
    rd(`ACL_OFF_COUNT, d);
    chk(d, 8'hcd, "lower byte");
    rd(3'h0, d);
    chk(d, 8'h00, "unmapped read");
    wr(`ACL_OFF_CMD, `ACL_OP_VFY_X);
    chk(cmd_info.count, 16'habcd, "doubled count");
    fin(`ACL_ST_GOOD, `ACL_ER_NONE);
    $display("test regs done");
  endtask
  task t_decode;
    logic [7:0] op [0:21] = '{8'hf8, 8'h27, 8'hf9, 8'h37, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5,
      8'hf6, 8'h40, 8'h41, 8'h42, 8'h90, 8'he7, 8'hea, 8'h50, 8'hef, 8'hb0,
      8'h10, 8'h7a, 8'hd5};
    int fl [0:21] = '{0, 0, 2, 0, 1, 1, 1, 1, 1, 1, 2, 2, 0, 1, 1, 0, 2, 1, 1, 3, 3, 4};
    for (int i = 0; i < 22; i++) begin
      wr(`ACL_OFF_UNIT, 8'h5f);
      wr(`ACL_OFF_CMD, op[i]);
      chk(cmd_start, fl[i] < 3, "start");
      if (fl[i] < 3) chk(cmd_info.opcode, op[i], "opcode");
      if (fl[i] == 1) chk({cmd_info.drive, cmd_info.head}, 5'h10, "drive only");
      if (fl[i] == 2) chk({cmd_info.drive, cmd_info.head}, 5'h1f, "drive head");
      fin(fl[i] == 4 ? `ACL_ST_ERR : `ACL_ST_GOOD, fl[i] == 4 ? `ACL_ER_ABORT : 8'h00);
    end
    $display("test decode done");
  endtask
  task t_dma(input logic [7:0] op, input logic [15:0] sc, input logic ab);
    int rem;
    rem = int'(sc) * 128;
    mtop = mtop + 32'(rem);
    wr(`ACL_OFF_UNIT, 8'h40);
    wr(`ACL_OFF_COUNT, sc[15:8]);
    wr(`ACL_OFF_COUNT, sc[7:0]);
    wr(`ACL_OFF_CMD, op);
    chk(busy, 1'b1, "busy");
    while (rem > 0) begin
      wfis(rem >= 2048 ? 12'h800 : rem[11:0], ab);
      rem = ab ? 0 : rem - (rem >= 2048 ? 2048 : rem);
    end
    fin(ab ? `ACL_ST_ERR : `ACL_ST_GOOD, ab ? `ACL_ER_ABORT : `ACL_ER_NONE);
    $display("test dma %0h done", op);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////
  // watchdog
  initial begin
    #300000;
    fails++;
    $display("mismatch at %0t: watchdog", $time);
    summarize;
  end
  // main sequence
  initial begin
    {rst_n, tf_wr, tf_rd, ctl_wr, media_err, slow} = 6'h00;
    {tf_addr, tf_wdata, ctl_wdata} = 19'h0;
    {mcnt, mtop, tcnt, fails, checks_done} = 160'h0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_regs;
    t_decode;
    slow = 1'b1;
    t_dma(`ACL_OP_RD_DMA, 16'h0001, 1'b0);
    slow = 1'b0;
    t_dma(`ACL_OP_RD_DMAX, 16'h0011, 1'b0);
    t_dma(`ACL_OP_RD_DMA, 16'h0011, 1'b1);
    summarize;
  end
endmodule
